// [gcsp_pkg.sv]
package gcsp_pkg;
    // control word layout
    localparam int unsigned WORD_W    = 8;
    localparam int unsigned LEVEL_W   = 2;
    localparam int unsigned GAIN_W    = 6;
    localparam int unsigned LEVEL_MSB = 7;
    localparam int unsigned LEVEL_LSB = 6;
    localparam int unsigned GAIN_MSB  = 5;
    localparam int unsigned GAIN_LSB  = 0;

    // legal gain code span
    localparam logic [5:0] GAIN_MIN = 6'h01;
    localparam logic [5:0] GAIN_MAX = 6'h3C;

    // values after reset
    localparam logic [7:0] RST_WORD   = 8'h01;
    localparam logic [1:0] RST_LEVEL  = 2'h0;
    localparam logic [5:0] RST_GAIN   = 6'h01;
    localparam logic       RST_MASTER = 1'b0;

    // synchroniser vector order and reset levels
    localparam int unsigned PIN_CNT   = 5;
    localparam int unsigned PIN_SCLK  = 0;
    localparam int unsigned PIN_LWN   = 1;
    localparam int unsigned PIN_SIN   = 2;
    localparam int unsigned PIN_TX    = 3;
    localparam int unsigned PIN_SLPN  = 4;
    localparam logic [4:0]  RST_PINS  = 5'h02;

    typedef enum logic {
        LW_HELD,
        LW_OPEN
    } gcsp_win_t;
endpackage

// [gcsp_sync.sv]
`timescale 1ns/10ps
module gcsp_sync #(
    parameter int unsigned      W       = 1,
    parameter logic [W-1:0]     RST_VAL = '0
) (
    // clock and reset
    input  wire logic           ref_clk_i,
    input  wire logic           arst_n_i,
    // asynchronous levels in, synchronised levels out
    input  wire logic [W-1:0]   async_i,
    output logic      [W-1:0]   sync_o
);
    logic [W-1:0] stage1;
    logic [W-1:0] next_stage1;
    logic [W-1:0] next_sync;

    always_comb begin
        next_stage1 = async_i;
        next_sync   = stage1;
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stage1 <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            stage1 <= next_stage1;
            sync_o <= next_sync;
        end
    end
endmodule // gcsp_sync

// [gcsp_port.sv]
`timescale 1ns/10ps
// Operation
// - transmit gate low disables, high enables
// - window rising edge applies shifted word
// - window high: serial clock edges ignored
// - window falling edge opens shift register to serial bits
// - window low: serial bits accepted
// - eight-bit word, most significant bit first
// - serial clock rise captures bit into master
// - serial clock fall moves master to slave
// - sleep low powers down, high powers up
// - bits 7:6 level, bits 5:0 gain
// - gain codes 01 to 60, 1 dB steps
// - transmit gate acts independent of serial clock
module gcsp_port (
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        arst_n_i,
    // serial control pins
    input  wire logic        serial_clk_i,
    input  wire logic        load_window_n_i,
    input  wire logic        serial_in_i,
    // power control pins
    input  wire logic        transmit_gate_i,
    input  wire logic        sleep_n_i,
    // applied settings
    output logic [1:0]       drive_level_select_o,
    output logic [5:0]       gain_code_o,
    output logic             gain_reserved_o,
    output logic             word_applied_o,
    // power state
    output logic             tx_enable_o,
    output logic             power_up_o
);
    function automatic logic gain_is_reserved(input logic [5:0] code);
        gain_is_reserved = (code < gcsp_pkg::GAIN_MIN) || (code > gcsp_pkg::GAIN_MAX);
    endfunction

    logic [gcsp_pkg::PIN_CNT-1:0] pins_s;
    logic                         s_sclk;
    logic                         s_lwn;
    logic                         s_sin;
    logic                         s_tx;
    logic                         s_slpn;

    // every pin passes two flip-flops before use
    gcsp_sync #(
        .W       (gcsp_pkg::PIN_CNT),
        .RST_VAL (gcsp_pkg::RST_PINS)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .arst_n_i  (arst_n_i),
        .async_i   ({sleep_n_i, transmit_gate_i, serial_in_i, load_window_n_i, serial_clk_i}),
        .sync_o    (pins_s)
    );

    assign s_sclk = pins_s[gcsp_pkg::PIN_SCLK];
    assign s_lwn  = pins_s[gcsp_pkg::PIN_LWN];
    assign s_sin  = pins_s[gcsp_pkg::PIN_SIN];
    assign s_tx   = pins_s[gcsp_pkg::PIN_TX];
    assign s_slpn = pins_s[gcsp_pkg::PIN_SLPN];

    // edge history
    logic sclk_d;
    logic lwn_d;
    logic sclk_rise;
    logic sclk_fall;
    logic lw_rise;
    logic lw_fall;

    assign sclk_rise = s_sclk & ~sclk_d;
    assign sclk_fall = ~s_sclk & sclk_d;
    assign lw_rise   = s_lwn & ~lwn_d;
    assign lw_fall   = ~s_lwn & lwn_d;

    // window state and shift register
    gcsp_pkg::gcsp_win_t              state;
    gcsp_pkg::gcsp_win_t              next_state;
    logic                             master;
    logic                             next_master;
    logic [gcsp_pkg::WORD_W-1:0]      shift_reg;
    logic [gcsp_pkg::WORD_W-1:0]      next_shift_reg;
    logic                             shift_open;
    logic                             apply;

    // serial clock counts only while the window is open and still low
    assign shift_open = (state == gcsp_pkg::LW_OPEN) && !s_lwn;
    assign apply      = (state == gcsp_pkg::LW_OPEN) && lw_rise;

    // applied settings
    logic [1:0] next_level;
    logic [5:0] next_gain;
    logic       next_reserved;
    logic       next_applied;
    logic       next_tx;
    logic       next_pwr;

    always_comb begin
        next_state     = state;
        next_master    = master;
        next_shift_reg = shift_reg;
        next_level     = drive_level_select_o;
        next_gain      = gain_code_o;
        next_reserved  = gain_reserved_o;
        next_applied   = 1'b0;
        case (state)
            gcsp_pkg::LW_HELD: begin
                if (lw_fall) begin
                    next_state = gcsp_pkg::LW_OPEN;
                end
            end
            gcsp_pkg::LW_OPEN: begin
                if (lw_rise) begin
                    next_state = gcsp_pkg::LW_HELD;
                end
            end
            default: begin
                next_state = gcsp_pkg::LW_HELD;
            end
        endcase
        if (shift_open && sclk_rise) begin
            next_master = s_sin;
        end
        if (shift_open && sclk_fall) begin
            // msb first: older bits move up, oldest beyond eight drop out
            next_shift_reg = {shift_reg[gcsp_pkg::WORD_W-2:0], master};
        end
        if (apply) begin
            next_level    = shift_reg[gcsp_pkg::LEVEL_MSB:gcsp_pkg::LEVEL_LSB];
            next_gain     = shift_reg[gcsp_pkg::GAIN_MSB:gcsp_pkg::GAIN_LSB];
            next_reserved = gain_is_reserved(shift_reg[gcsp_pkg::GAIN_MSB:gcsp_pkg::GAIN_LSB]);
            next_applied  = 1'b1;
        end
        next_tx  = s_tx;
        next_pwr = s_slpn;
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sclk_d               <= 1'b0;
            lwn_d                <= 1'b1;
            state                <= gcsp_pkg::LW_HELD;
            master               <= gcsp_pkg::RST_MASTER;
            shift_reg            <= gcsp_pkg::RST_WORD;
            drive_level_select_o <= gcsp_pkg::RST_LEVEL;
            gain_code_o          <= gcsp_pkg::RST_GAIN;
            gain_reserved_o      <= 1'b0;
            word_applied_o       <= 1'b0;
            tx_enable_o          <= 1'b0;
            power_up_o           <= 1'b0;
        end else begin
            sclk_d               <= s_sclk;
            lwn_d                <= s_lwn;
            state                <= next_state;
            master               <= next_master;
            shift_reg            <= next_shift_reg;
            drive_level_select_o <= next_level;
            gain_code_o          <= next_gain;
            gain_reserved_o      <= next_reserved;
            word_applied_o       <= next_applied;
            tx_enable_o          <= next_tx;
            power_up_o           <= next_pwr;
        end
    end

    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_win_rise;
        (state == gcsp_pkg::LW_OPEN) && lw_rise;
    endsequence

    sequence s_bit_fall;
        shift_open && sclk_fall;
    endsequence

    chk_word_applied: assert property (
        s_win_rise |=> (gain_code_o == $past(shift_reg[5:0]))
            && (drive_level_select_o == $past(shift_reg[7:6])) && word_applied_o)
        else $error("window rise did not apply the shifted word");

    chk_held_no_shift: assert property (
        (state == gcsp_pkg::LW_HELD) |=> $stable(shift_reg) && $stable(master))
        else $error("shift register moved while window held");

    chk_settings_frozen: assert property (
        !((state == gcsp_pkg::LW_OPEN) && lw_rise) |=> $stable(gain_code_o)
            && $stable(drive_level_select_o) && $stable(gain_reserved_o))
        else $error("settings changed without a window rise");

    chk_applied_single: assert property (
        word_applied_o |=> !word_applied_o)
        else $error("word applied strobe stood longer than one cycle");

    chk_slave_shift: assert property (
        s_bit_fall |=> shift_reg == {$past(shift_reg[6:0]), $past(master)})
        else $error("falling serial clock did not shift master into slave");

    chk_master_capture: assert property (
        shift_open && sclk_rise |=> master == $past(s_sin))
        else $error("rising serial clock did not capture data");

    chk_open_accepts: assert property (
        (state == gcsp_pkg::LW_HELD) && lw_fall |=> shift_open)
        else $error("open window refused a serial bit");

    chk_msb_first: assert property (
        s_win_rise |=> drive_level_select_o[1] == $past(shift_reg[7]))
        else $error("first bit did not land in the level msb");

    chk_reserved_flag: assert property (
        s_win_rise |=> gain_reserved_o == gain_is_reserved($past(shift_reg[5:0])))
        else $error("reserved gain flag wrong");

    chk_tx_follow: assert property (
        transmit_gate_i [*3] |=> tx_enable_o)
        else $error("transmit enable did not follow gate high");

    chk_tx_gate_low: assert property (
        (!transmit_gate_i) [*3] |=> !tx_enable_o)
        else $error("transmit enable did not drop with gate low");

    chk_sleep_follow: assert property (
        (!sleep_n_i) [*3] |=> !power_up_o)
        else $error("device not powered down while sleep low");
endmodule // gcsp_port

// [gcsp_host_model.sv]
`timescale 1ns/10ps
module gcsp_host_model (
    // clock
    input  wire logic ref_clk_i,
    // serial control lines toward the device
    output logic      serial_clk_o,
    output logic      load_window_n_o,
    output logic      serial_in_o
);
    initial begin
        serial_clk_o    = 1'b0;
        load_window_n_o = 1'b1;
        serial_in_o     = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask

    // one clock pulse, data set up four cycles ahead of the rise
    task automatic pulse(input logic b);
        serial_in_o = b;
        hold(4);
        serial_clk_o = 1'b1;
        hold(4);
        serial_clk_o = 1'b0;
    endtask

    // frame of n bits, msb first
    task automatic send(input logic [15:0] w, input int n);
        load_window_n_o = 1'b0;
        hold(4);
        for (int i = n - 1; i >= 0; i--) begin
            pulse(w[i]);
        end
        // let the last falling edge shift before the window closes
        hold(4);
        load_window_n_o = 1'b1;
        // released data line shows the inverse of its last value
        serial_in_o = ~serial_in_o;
    endtask

    // clock pulses with the window closed
    task automatic stray(input int n);
        for (int i = 0; i < n; i++) begin
            pulse(~serial_in_o);
        end
    endtask
endmodule // gcsp_host_model

// [tb_gain_current_serial_port.sv]
`timescale 1ns/10ps
module tb_gain_current_serial_port;
    logic        ref_clk_i;
    logic        arst_n_i;
    logic        sclk;
    logic        win_n;
    logic        sin;
    logic        gate;
    logic        sleep_n;
    logic [1:0]  level;
    logic [5:0]  gain;
    logic        resv;
    logic        applied;
    logic        tx_en;
    logic        pwr;
    int          bad_count   = 0;
    int          checks_done = 0;
    logic [31:0] seed        = 32'h2BE0;
    logic [7:0]  prev_w      = 8'h01;
    logic        seen;
    logic [7:0]  corner [4]  = '{8'hFC, 8'h00, 8'h3D, 8'h41};

    gcsp_host_model gcsp_host_model_i (.ref_clk_i(ref_clk_i), .serial_clk_o(sclk),
        .load_window_n_o(win_n), .serial_in_o(sin));
    gcsp_port gcsp_port_i (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .serial_clk_i(sclk),
        .load_window_n_i(win_n), .serial_in_i(sin), .transmit_gate_i(gate),
        .sleep_n_i(sleep_n), .drive_level_select_o(level), .gain_code_o(gain),
        .gain_reserved_o(resv), .word_applied_o(applied), .tx_enable_o(tx_en),
        .power_up_o(pwr));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // slave contents after n bits: older bits move up, last eight kept
    function automatic logic [7:0] exp_word(input logic [7:0] p, input logic [15:0] w,
                                            input int n);
        logic [15:0] x;
        x = ({8'h00, p} << n) | (w & ((16'h0001 << n) - 16'h0001));
        return x[7:0];
    endfunction

    function automatic logic exp_resv(input logic [5:0] g);
        return (g < gcsp_pkg::GAIN_MIN) || (g > gcsp_pkg::GAIN_MAX);
    endfunction

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic frame(input logic [15:0] w, input int n);
        logic [7:0] e;
        int         t;
        e = exp_word(prev_w, w, n);
        gcsp_host_model_i.send(w, n);
        chk("gain_held", {2'h0, prev_w[5:0]}, {2'h0, gain});
        t = 0;
        while (applied !== 1'b1 && t < 10) begin
            @(negedge ref_clk_i);
            t++;
        end
        if (applied !== 1'b1) begin
            bad_count++;
            $display("Error word_applied_o expected 1 seen %b", applied);
            wrap_up();
        end
        chk("level", {6'h00, e[7:6]}, {6'h00, level});
        chk("gain", {2'h0, e[5:0]}, {2'h0, gain});
        chk("reserved", {7'h00, exp_resv(e[5:0])}, {7'h00, resv});
        @(negedge ref_clk_i);
        chk("applied_pulse", 8'h00, {7'h00, applied});
        prev_w = e;
    endtask

    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end

    initial begin
        arst_n_i = 1'b0;
        gate     = 1'b0;
        sleep_n  = 1'b1;
        repeat (6) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        arst_n_i = 1'b1;
        repeat (4) @(negedge ref_clk_i);
        chk("reset_gain", 8'h01, {2'h0, gain});
        chk("reset_level", 8'h00, {6'h00, level});
        $display("test reset done");
        for (int k = 0; k < 12; k++) begin
            frame({8'h00, (k < 4) ? corner[k] : seed[7:0]}, 8);
            seed = lfsr(seed);
        end
        $display("test frames done");
        frame(16'h02A5, 10);
        $display("test long frame done");
        seen = 1'b0;
        fork
            gcsp_host_model_i.stray(3);
            repeat (44) begin
                @(negedge ref_clk_i);
                seen = seen | (applied === 1'b1);
            end
        join
        chk("stray_pulse", 8'h00, {7'h00, seen});
        chk("stray_gain", {2'h0, prev_w[5:0]}, {2'h0, gain});
        // short frame keeps the older bits, so a stray shift would show
        frame({12'h000, seed[11:8]}, 4);
        $display("test closed window done");
        for (int k = 0; k < 8; k++) begin
            gate    = 1'b0;
            sleep_n = seed[0];
            repeat (4) @(negedge ref_clk_i);
            gate = seed[1];
            repeat (4) @(negedge ref_clk_i);
            chk("tx_enable", {7'h00, seed[1]}, {7'h00, tx_en});
            chk("power_up", {7'h00, seed[0]}, {7'h00, pwr});
            seed = lfsr(seed);
        end
        $display("test power pins done");
        wrap_up();
    end
endmodule // tb_gain_current_serial_port
